// [ebw_bus_engine.v]
// External expansion bus engine: strobe, chip selects, wait states
`timescale 1ns/10ps
`default_nettype none
`include "ebw_defines.vh"

// How it works
// - Automatic wait enabled stretches every external access by one cycle, except peripheral frame accesses that get peripheral waits.
// - Read data latched 1.5, 2.5 or 3.5 cycles after address valid.
// - Read data latched 1, 2 or 3 cycles after select falls.
// - Data strobe follows exactly the same timing as the chip selects.
// - Rising edge of the active select ends the transfer.
// - Peripheral frame gets extra waits only when that waiting is enabled.
// - Strobe low one cycle with no wait, three with peripheral waits.
// - Write data valid 0.75, 1.75 or 2.75 cycles before strobe rises.
// - Write data held about 0.75 cycle after strobe rises.
// - After a read, bus not driven for 1.25 cycles after strobe rises.
// - One system cycle equals four input clock periods.
module ebw_bus_engine (
  input wire ref_clk,
  input wire rst_b,
  input wire autoWaitEn,
  input wire periphWaitEn,
  input wire reqValid,
  output wire reqReady,
  input wire reqWrite,
  input wire [`EBW_ADDR_W-1:0] reqAddr,
  input wire [`EBW_DATA_W-1:0] reqWrData,
  input wire [`EBW_CS_IDX_W-1:0] reqCsSel,
  output reg [`EBW_DATA_W-1:0] rdData,
  output reg rdValid,
  output reg xferDone,
  output reg [`EBW_ADDR_W-1:0] busAddr,
  output reg busRead,
  output reg extDataStrobe_b,
  output reg [`EBW_NUM_CS-1:0] chipSel_b,
  output reg [`EBW_DATA_W-1:0] busDataOut,
  output reg busDataOe_b,
  input wire [`EBW_DATA_W-1:0] busDataIn
);

  // ==========================================================
  // State
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] qCnt_r;
  reg [4:0] qCnt_nxt;
  reg [1:0] waits_r;
  reg write_r;
  reg [`EBW_CS_IDX_W-1:0] csSel_r;
  reg [2:0] turnCnt_r;
  reg [`EBW_ADDR_W-1:0] addrHeld_r;
  reg [`EBW_SYNC_TAP-1:0] latchPipe_r;
  reg [1:0] reqWaits;
  reg [4:0] riseQ;
  reg [4:0] endQ;
  reg [`EBW_NUM_CS-1:0] csOneHot;
  wire [`EBW_DATA_W-1:0] dataSync;
  wire dataStable;
  wire strobeLow;
  wire driveWin;
  wire latchNow;
  wire lastQ;
  wire startReq;

  // ==========================================================
  // Read data pin synchroniser
  ebw_sync3 #(
    .WIDTH(`EBW_DATA_W)
  ) u_dataSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn(busDataIn),
    .syncOut(dataSync),
    .stable(dataStable)
  );

  // ==========================================================
  // Wait state choice per request
  always @* begin
    reqWaits = `EBW_WAIT_NONE;
    if (reqCsSel == `EBW_CS_PERIPH && periphWaitEn) begin
      reqWaits = `EBW_WAIT_PERIPH;
    end else if (autoWaitEn) begin
      reqWaits = `EBW_WAIT_AUTO;
    end
  end

  // ==========================================================
  // Phase points of the running access, in input clocks
  always @* begin
    // Strobe stays low one system cycle per (1 + waits)
    riseQ = `EBW_ADDR_TO_STROBE_Q + `EBW_STROBE_BASE_Q
      + {1'b0, waits_r, 2'b00};
    // Writes keep the data for the hold; address hold is shorter
    if (write_r) begin
      endQ = riseQ + `EBW_WDATA_HOLD_Q;
    end else begin
      endQ = riseQ + `EBW_ADDR_HOLD_Q;
    end
  end

  // Same window drives strobe and select
  assign strobeLow = (state_r == ST_RUN) && (qCnt_r >= `EBW_ADDR_TO_STROBE_Q)
    && (qCnt_r < riseQ);
  // Write data from 0.25 cycle into the strobe, never during turnaround
  assign driveWin = (state_r == ST_RUN) && write_r && (turnCnt_r == 3'h0)
    && (qCnt_r >= `EBW_WDATA_START_Q) && (qCnt_r < endQ);
  // Sample edge coincides with the select rising
  assign latchNow = (state_r == ST_RUN) && !write_r && (qCnt_r == riseQ);
  assign lastQ = (state_r == ST_RUN) && (qCnt_r == endQ);
  // A write waits out the read turnaround before it starts
  assign startReq = reqValid && (state_r == ST_IDLE)
    && (!reqWrite || turnCnt_r == 3'h0);
  assign reqReady = (state_r == ST_IDLE) && (!reqWrite || turnCnt_r == 3'h0);

  // ==========================================================
  // One-hot select decode; the none code leaves only the strobe
  always @* begin
    csOneHot = {`EBW_NUM_CS{1'b0}};
    if (csSel_r < `EBW_NUM_CS) begin
      csOneHot[csSel_r] = 1'b1;
    end
  end

  // ==========================================================
  // Sequencer
  always @* begin
    state_nxt = state_r;
    qCnt_nxt = qCnt_r;
    case (state_r)
      ST_IDLE: begin
        qCnt_nxt = 5'h00;
        if (startReq) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        qCnt_nxt = qCnt_r + 5'h01;
        if (lastQ) begin
          state_nxt = ST_IDLE;
          qCnt_nxt = 5'h00;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        qCnt_nxt = 5'h00;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      qCnt_r <= 5'h00;
      waits_r <= `EBW_WAIT_NONE;
      write_r <= 1'b0;
      csSel_r <= `EBW_CS_NONE;
      addrHeld_r <= {`EBW_ADDR_W{1'b0}};
      busAddr <= {`EBW_ADDR_W{1'b0}};
      busRead <= 1'b1;
      busDataOut <= {`EBW_DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      qCnt_r <= qCnt_nxt;
      if (startReq) begin
        waits_r <= reqWaits;
        write_r <= reqWrite;
        csSel_r <= reqCsSel;
        addrHeld_r <= reqAddr;
        busDataOut <= reqWrData;
      end
      // Address leads the strobe by half a cycle, not three quarters
      if (state_r == ST_RUN && qCnt_r == 5'h00) begin
        busAddr <= addrHeld_r;
        busRead <= !write_r;
      end
    end
  end

  // ==========================================================
  // Pin drivers, registered from the phase windows
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      extDataStrobe_b <= 1'b1;
      chipSel_b <= `EBW_CS_ALL_OFF;
      busDataOe_b <= 1'b1;
      xferDone <= 1'b0;
    end else begin
      extDataStrobe_b <= !strobeLow;
      chipSel_b <= strobeLow ? ~csOneHot : `EBW_CS_ALL_OFF;
      busDataOe_b <= !driveWin;
      xferDone <= (state_r == ST_RUN) && (qCnt_r == riseQ);
    end
  end

  // ==========================================================
  // Read turnaround guard; memories may still release the bus
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      turnCnt_r <= 3'h0;
    end else if (latchNow) begin
      turnCnt_r <= `EBW_TURN_Q - 3'h1;
    end else if (turnCnt_r != 3'h0) begin
      turnCnt_r <= turnCnt_r - 3'h1;
    end
  end

  // ==========================================================
  // Read capture; the pin value of the sample edge is read from the
  // synchroniser output three clocks later
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      latchPipe_r <= {`EBW_SYNC_TAP{1'b0}};
      rdData <= {`EBW_DATA_W{1'b0}};
      rdValid <= 1'b0;
    end else begin
      latchPipe_r <= {latchPipe_r[`EBW_SYNC_TAP-2:0], latchNow};
      rdValid <= latchPipe_r[`EBW_SYNC_TAP-1];
      if (latchPipe_r[`EBW_SYNC_TAP-1]) begin
        rdData <= dataSync;
      end
    end
  end

  // Agreement flag unused: capture point is fixed by the timing
  wire unusedStable;
  assign unusedStable = dataStable;

endmodule // ebw_bus_engine

`default_nettype wire

// [ebw_chk_sva.sv]
// Checker for strobe, select and data bus timing of the bus engine
`timescale 1ns/10ps
`default_nettype none
module ebw_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic autoWaitEn,
  input wire logic periphWaitEn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [2:0] reqCsSel,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic xferDone,
  input wire logic busRead,
  input wire logic [15:0] busAddr,
  input wire logic extDataStrobe_b,
  input wire logic [5:0] chipSel_b,
  input wire logic busDataOe_b,
  input wire logic [7:0] busDataIn
);
  // ==========================================================
  // Helpers: waits of the access in flight, strobe low count
  logic [1:0] wq_r;
  logic [3:0] lowCnt_r;
  wire stb = extDataStrobe_b;
  wire oe = busDataOe_b;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wq_r <= 2'h0;
      lowCnt_r <= 4'h0;
    end else begin
      if (reqValid && reqReady)
        wq_r <= (reqCsSel == 3'h5 && periphWaitEn) ? 2'h2 : {1'b0, autoWaitEn};
      lowCnt_r <= stb ? 4'h0 : lowCnt_r + 4'h1;
    end
  end
  // ==========================================================
  // Properties
  property p_csMatch; stb |-> chipSel_b == 6'h3f; endproperty
  a_csMatch: assert property (p_csMatch)
    else $error("select low outside strobe");
  property p_oneCs; $countones(~chipSel_b) <= 1; endproperty
  a_oneCs: assert property (p_oneCs)
    else $error("several selects low");
  property p_done; $rose(stb) == xferDone; endproperty
  a_done: assert property (p_done)
    else $error("done not at strobe rise");
  property p_lowNone; $rose(stb) && wq_r == 2'h0 |-> lowCnt_r == 4'h4;
  endproperty
  a_lowNone: assert property (p_lowNone)
    else $error("strobe width wrong, no wait");
  property p_lowAuto; $rose(stb) && wq_r == 2'h1 |-> lowCnt_r == 4'h8;
  endproperty
  a_lowAuto: assert property (p_lowAuto)
    else $error("strobe width wrong, one wait");
  property p_lowPeriph; $rose(stb) && wq_r == 2'h2 |-> lowCnt_r == 4'hc;
  endproperty
  a_lowPeriph: assert property (p_lowPeriph)
    else $error("strobe width wrong, frame waits");
  property p_rdSample;
    $rose(stb) && busRead |-> ##3 rdValid && rdData == $past(busDataIn, 4);
  endproperty
  a_rdSample: assert property (p_rdSample)
    else $error("read data not from sample edge");
  property p_addrLead; $changed(busAddr) |-> ##2 $fell(stb); endproperty
  a_addrLead: assert property (p_addrLead)
    else $error("address lead to strobe wrong");
  property p_wrSetup; $rose(stb) && !busRead |-> !oe && !$past(oe, 3);
  endproperty
  a_wrSetup: assert property (p_wrSetup)
    else $error("write data late");
  property p_wrHold; $rose(stb) && !busRead |-> !oe [*3] ##1 oe; endproperty
  a_wrHold: assert property (p_wrHold)
    else $error("write data hold wrong");
  property p_rdTurn; $rose(stb) && busRead |-> oe [*5]; endproperty
  a_rdTurn: assert property (p_rdTurn)
    else $error("bus driven too soon after read");
  c_periph: cover property ($rose(stb) && wq_r == 2'h2);
  c_write: cover property ($rose(stb) && !busRead);
  c_read: cover property (rdValid);
endmodule // ebw_chk
`default_nettype wire

// [ebw_defines.vh]
// Timing, width and encoding constants of the external bus wait engine
`ifndef EBW_DEFINES_VH
`define EBW_DEFINES_VH

// ==========================================================
// Clocks
`define EBW_REF_PERIOD_NS 25
`define EBW_QTR_PER_CYCLE 4
`define EBW_SYS_CYCLE_NS (`EBW_QTR_PER_CYCLE * `EBW_REF_PERIOD_NS)

// ==========================================================
// Access phases, in quarter system cycles (input clock periods)
`define EBW_ADDR_TO_STROBE_Q 5'h02
`define EBW_WDATA_START_Q 5'h03
`define EBW_STROBE_BASE_Q 5'h04
`define EBW_ADDR_HOLD_Q 5'h02
`define EBW_WDATA_HOLD_Q 5'h03
`define EBW_TURN_Q 3'h5

// ==========================================================
// Wait states
`define EBW_WAIT_NONE 2'h0
`define EBW_WAIT_AUTO 2'h1
`define EBW_WAIT_PERIPH 2'h2

// ==========================================================
// Chip selects
`define EBW_NUM_CS 6
`define EBW_CS_IDX_W 3
`define EBW_CS_PERIPH 3'h5
`define EBW_CS_NONE 3'h7
`define EBW_CS_ALL_OFF 6'h3_f

// ==========================================================
// Buses
`define EBW_ADDR_W 16
`define EBW_DATA_W 8
`define EBW_SYNC_TAP 2'h3

`endif

// [ebw_mem_model.sv]
// Memory model on the far side of the expansion bus
`timescale 1ns/10ps
`default_nettype none
module ebw_mem_model (
  input wire logic ref_clk,
  input wire logic strobe_b,
  input wire logic busRead,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [1:0] lat,
  output var logic [7:0] rdOut
);
  // ==========================================================
  // Storage; lat above 2 would miss the no-wait sample edge
  logic [7:0] mem [0:255];
  logic [1:0] lowCnt_r = 2'h0;
  logic stbQ_r = 1'b1;
  initial rdOut = 8'h00;
  always @(posedge ref_clk) begin
    stbQ_r <= strobe_b;
    lowCnt_r <= strobe_b ? 2'h0 : lowCnt_r + {1'b0, lowCnt_r != 2'h3};
    if (!strobe_b && busRead && lowCnt_r >= lat)
      rdOut <= mem[addr];
    else
      rdOut <= ~rdOut;
    if (strobe_b && !stbQ_r && !busRead)
      mem[addr] <= wrData;
  end
endmodule // ebw_mem_model
`default_nettype wire

// [ebw_sync3.v]
// Three-stage input synchroniser with agreement flag
`timescale 1ns/10ps
`default_nettype none

module ebw_sync3 #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut,
  output wire stable
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;

  // Stage one feeds stage two only
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  assign syncOut = stage3_r;
  assign stable = (stage2_r == stage3_r);

endmodule // ebw_sync3

`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the expansion bus engine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic autoWaitEn = 1'b0;
  logic periphWaitEn = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0] reqWrData = 8'h00;
  logic [2:0] reqCsSel = 3'h0;
  logic [1:0] lat = 2'h0;
  wire reqReady, rdValid, xferDone, busRead, extDataStrobe_b, busDataOe_b;
  wire [7:0] rdData, busDataOut, busDataIn;
  wire [15:0] busAddr;
  wire [5:0] chipSel_b;
  int failures = 0;
  int compares = 0;
  int seed = 45537;
  int r;
  logic [7:0] shadow [0:255];
  bit written [0:255];
  always #12.5 ref_clk = ~ref_clk;
  ebw_bus_engine dut_u (.ref_clk, .rst_b, .autoWaitEn, .periphWaitEn,
    .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWrData, .reqCsSel,
    .rdData, .rdValid, .xferDone, .busAddr, .busRead, .extDataStrobe_b,
    .chipSel_b, .busDataOut, .busDataOe_b, .busDataIn);
  ebw_mem_model mem_u (.ref_clk, .strobe_b(extDataStrobe_b), .busRead,
    .addr(busAddr[7:0]), .wrData(busDataOut), .lat, .rdOut(busDataIn));
  // ==========================================================
  // Checking and transfer tasks
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chkData(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chkSel(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t sel %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] selOf(input logic [2:0] cs);
    return cs < 3'h6 ? ~(6'h01 << cs) : 6'h3f;
  endfunction
  task xfer(input bit wr, input logic [2:0] cs, input logic [7:0] a,
      input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqCsSel <= cs;
    reqAddr <= {8'h40, a};
    reqWrData <= d;
    n = 0;
    @(negedge ref_clk);
    while (reqReady !== 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
    @(posedge ref_clk);
    reqValid <= 1'b0;
    while (xferDone !== 1'b1 && n < 80) begin
      @(negedge ref_clk);
      n++;
      if (extDataStrobe_b === 1'b0) chkSel(chipSel_b, selOf(cs));
    end
    if (wr) begin
      shadow[a] = d;
      written[a] = 1'b1;
    end else begin
      while (rdValid !== 1'b1 && n < 90) begin @(negedge ref_clk); n++; end
      chkData(rdData, shadow[a]);
    end
    if (n >= 80) begin
      failures++;
      results;
    end
  endtask
  // ==========================================================
  // Corner table, then random traffic
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      @(posedge ref_clk);
      autoWaitEn <= k[0];
      periphWaitEn <= k[1];
      lat <= 2'h2;
      xfer(1'b1, k[4:2], k[7:0], ~k[7:0]);
      xfer(1'b0, k[4:2], k[7:0], 8'h00);
    end
    repeat (80) begin
      r = $random(seed);
      @(posedge ref_clk);
      autoWaitEn <= r[0];
      periphWaitEn <= r[1];
      lat <= r[2] ? 2'h2 : {1'b0, r[3]};
      xfer(r[4] || !written[r[15:8]], r[7:5], r[15:8], r[23:16]);
    end
    results;
  end
  initial begin
    #2000000;
    failures++;
    results;
  end
endmodule // tb_top
bind ebw_bus_engine ebw_chk chk_u (.ref_clk, .rst_b, .autoWaitEn,
  .periphWaitEn, .reqValid, .reqReady, .reqCsSel, .rdData, .rdValid,
  .xferDone, .busAddr, .busRead, .extDataStrobe_b, .chipSel_b, .busDataOe_b,
  .busDataIn);
`default_nettype wire
